// >>> rtl/sod_cfg_field.sv
// Holds one writable register field with a constant reset value.
`timescale 1ns/10ps
module sod_cfg_field #(
   parameter int          WIDTH    = 8,
   parameter logic [7:0]  RESET_VAL = 8'h00
) (
   // Clock and synchronised reset.
   input  wire logic             clock,
   input  wire logic             rstSync_n,
   // Write side.
   input  wire logic             wrEn,
   input  wire logic [WIDTH-1:0] wrData,
   // Stored value.
   output logic      [WIDTH-1:0] value
);

   // ------------------------------------------------------------------
   // Storage.
   // ------------------------------------------------------------------
   logic [WIDTH-1:0] field_q;  // Stored field.
   logic [WIDTH-1:0] field_d;  // Next field value.

   // Loads the new data on a write, otherwise holds.
   always_comb begin
      field_d = field_q;
      if (wrEn) begin
         field_d = wrData;
      end
   end

   // Registers the field; reset takes the constant image.
   always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
         field_q <= RESET_VAL[WIDTH-1:0];
      end else begin
         field_q <= field_d;
      end
   end

   assign value = field_q;

endmodule

// >>> rtl/sod_divider_regs.sv
// Configuration register bank for the synthesizer dividers, crystal trim and output driver.
//
// What this block does
// - Trim bits 9..2 fill the high trim byte.
// - Trim bits 1..0 in low register; rest reserved.
// - Power-down bit seven disables the output buffer.
// - Format field selects tristate, LVPECL, LVDS, HCSL.
// - Output divider is nine bits, 5..511 valid.
// - Divider bit 8 from upper, lower resets 0x20.
// - Feedback divider is twelve bits from two bytes.
// - Feedback upper nibble, lower byte resets 0x32.
// - Numerator is 22 bits, top byte first.
// - Numerator bits 21..16 in first register low six.
// - Numerator middle and bottom bytes reset zero.
// - Denominator is 22 bits, top byte first.
// - Denominator top six bits, reset zero.
// - Rising calibration bit starts recalibration, self-clears.
`timescale 1ns/10ps
module sod_divider_regs (
   // Clock and reset.
   input  wire logic         clock,
   input  wire logic         rst_n,
   // Register access from the serial control engine.
   input  wire logic [7:0]   regAddr,
   input  wire logic [7:0]   regWrData,
   input  wire logic         regWrEn,
   input  wire logic         regRdEn,
   output logic      [7:0]   regRdData,
   // Analog synthesizer side.
   output logic      [9:0]   crystalTrimOffset,
   output logic      [8:0]   outputDivider,
   output logic              outputDividerReserved,
   output logic      [11:0]  feedbackIntegerDivider,
   output logic      [21:0]  fractionNumerator,
   output logic      [21:0]  fractionDenominator,
   output logic              calibrationStart,
   output logic              calibrationBusy,
   input  wire logic         calibrationDone,
   // Output driver side.
   output logic              outputBufferPowerdown,
   output logic      [1:0]   outputFormat,
   output logic              formatTristate,
   output logic              formatLvpecl,
   output logic              formatLvds,
   output logic              formatHcsl
);

   // ------------------------------------------------------------------
   // Reset release and input synchronisation.
   // ------------------------------------------------------------------
   logic       rstMeta_q;    // First reset release stage.
   logic       rstSync_n;    // Released reset used by all logic.
   logic       doneMeta_q;   // First stage of the done synchroniser.
   logic       doneSync_q;   // Second stage of the done synchroniser.
   logic       doneSync_d;   // Next value of the second stage.
   logic       doneMeta_d;   // Next value of the first stage.

   // Releases reset through two flip-flops so every register leaves reset together.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_n <= rstMeta_q;
      end
   end

   // The done flag comes from the analog domain and is synchronised first.
   always_comb begin
      doneMeta_d = calibrationDone;
      doneSync_d = doneMeta_q;
   end

   // Registers the done synchroniser.
   always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
         doneMeta_q <= 1'b0;
         doneSync_q <= 1'b0;
      end else begin
         doneMeta_q <= doneMeta_d;
         doneSync_q <= doneSync_d;
      end
   end

   // ------------------------------------------------------------------
   // Write decode.
   // ------------------------------------------------------------------
   logic wrTrimLow;    // Write to the low trim register.
   logic wrTrimHigh;   // Write to the high trim register.
   logic wrDriver;     // Write to the driver control register.
   logic wrOutUpper;   // Write to the output divider upper register.
   logic wrOutLower;   // Write to the output divider lower register.
   logic wrFbUpper;    // Write to the feedback divider upper register.
   logic wrFbLower;    // Write to the feedback divider lower register.
   logic wrNumTop;     // Write to the numerator top register.
   logic wrNumMid;     // Write to the numerator middle register.
   logic wrNumBot;     // Write to the numerator bottom register.
   logic wrDenTop;     // Write to the denominator top register.
   logic wrDenMid;     // Write to the denominator middle register.
   logic wrDenBot;     // Write to the denominator bottom register.
   logic wrCal;        // Write to the calibration control register.

   // Each strobe fires only when the address matches exactly.
   always_comb begin
      wrTrimLow  = regWrEn && (regAddr == sod_pkg::TRIM_LOW_ADDR);
      wrTrimHigh = regWrEn && (regAddr == sod_pkg::TRIM_HIGH_ADDR);
      wrDriver   = regWrEn && (regAddr == sod_pkg::DRIVER_CONTROL_ADDR);
      wrOutUpper = regWrEn && (regAddr == sod_pkg::OUT_DIV_UPPER_ADDR);
      wrOutLower = regWrEn && (regAddr == sod_pkg::OUT_DIV_LOWER_ADDR);
      wrFbUpper  = regWrEn && (regAddr == sod_pkg::FB_DIV_UPPER_ADDR);
      wrFbLower  = regWrEn && (regAddr == sod_pkg::FB_DIV_LOWER_ADDR);
      wrNumTop   = regWrEn && (regAddr == sod_pkg::NUM_TOP_ADDR);
      wrNumMid   = regWrEn && (regAddr == sod_pkg::NUM_MIDDLE_ADDR);
      wrNumBot   = regWrEn && (regAddr == sod_pkg::NUM_BOTTOM_ADDR);
      wrDenTop   = regWrEn && (regAddr == sod_pkg::DEN_TOP_ADDR);
      wrDenMid   = regWrEn && (regAddr == sod_pkg::DEN_MIDDLE_ADDR);
      wrDenBot   = regWrEn && (regAddr == sod_pkg::DEN_BOTTOM_ADDR);
      wrCal      = regWrEn && (regAddr == sod_pkg::CAL_CONTROL_ADDR);
   end

   // ------------------------------------------------------------------
   // Stored fields.
   // ------------------------------------------------------------------
   logic [1:0] trimLow;     // Trim bits 1..0.
   logic [7:0] trimHigh;    // Trim bits 9..2.
   logic       drvPd;       // Buffer power-down.
   logic [1:0] drvFmt;      // Output format.
   logic [7:0] outUpper;    // Output divider upper byte, bit 0 used.
   logic [7:0] outLower;    // Output divider bits 7..0.
   logic [3:0] fbUpper;     // Feedback divider bits 11..8.
   logic [7:0] fbLower;     // Feedback divider bits 7..0.
   logic [5:0] numTop;      // Numerator bits 21..16.
   logic [7:0] numMid;      // Numerator bits 15..8.
   logic [7:0] numBot;      // Numerator bits 7..0.
   logic [5:0] denTop;      // Denominator bits 21..16.
   logic [7:0] denMid;      // Denominator bits 15..8.
   logic [7:0] denBot;      // Denominator bits 7..0.

   // Low trim register keeps only its two defined bits.
   sod_cfg_field #(.WIDTH(sod_pkg::TRIM_LOW_W), .RESET_VAL(sod_pkg::TRIM_LOW_RST)) uTrimLow (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrTrimLow),
      .wrData(regWrData[sod_pkg::TRIM_LOW_W-1:0]), .value(trimLow));

   // High trim register is a full byte.
   sod_cfg_field #(.WIDTH(sod_pkg::BYTE_W), .RESET_VAL(sod_pkg::TRIM_HIGH_RST)) uTrimHigh (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrTrimHigh),
      .wrData(regWrData), .value(trimHigh));

   // Buffer power-down bit, outside the stored default image.
   sod_cfg_field #(.WIDTH(1), .RESET_VAL({7'h00, sod_pkg::PD_RST})) uDrvPd (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrDriver),
      .wrData(regWrData[sod_pkg::DRV_PD_BIT]), .value(drvPd));

   // Output format field, LVPECL after reset.
   sod_cfg_field #(.WIDTH(sod_pkg::DRV_FMT_W),
                   .RESET_VAL({6'h00, sod_pkg::FMT_LVPECL})) uDrvFmt (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrDriver),
      .wrData(regWrData[sod_pkg::DRV_FMT_W-1:0]), .value(drvFmt));

   // Output divider upper byte; its reserved bits are read-write storage.
   sod_cfg_field #(.WIDTH(sod_pkg::BYTE_W), .RESET_VAL(sod_pkg::OUT_UPPER_RST)) uOutUpper (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrOutUpper),
      .wrData(regWrData), .value(outUpper));

   // Output divider lower byte, resets to 0x20.
   sod_cfg_field #(.WIDTH(sod_pkg::BYTE_W), .RESET_VAL(sod_pkg::OUT_LOWER_RST)) uOutLower (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrOutLower),
      .wrData(regWrData), .value(outLower));

   // Feedback divider upper nibble.
   sod_cfg_field #(.WIDTH(sod_pkg::FB_UPPER_W), .RESET_VAL(sod_pkg::FB_UPPER_RST)) uFbUpper (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrFbUpper),
      .wrData(regWrData[sod_pkg::FB_UPPER_W-1:0]), .value(fbUpper));

   // Feedback divider lower byte, resets to 0x32.
   sod_cfg_field #(.WIDTH(sod_pkg::BYTE_W), .RESET_VAL(sod_pkg::FB_LOWER_RST)) uFbLower (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrFbLower),
      .wrData(regWrData), .value(fbLower));

   // Numerator top six bits; bits 7..6 are not stored.
   sod_cfg_field #(.WIDTH(sod_pkg::FRAC_TOP_W), .RESET_VAL(sod_pkg::FRAC_RST)) uNumTop (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrNumTop),
      .wrData(regWrData[sod_pkg::FRAC_TOP_W-1:0]), .value(numTop));

   // Numerator middle byte.
   sod_cfg_field #(.WIDTH(sod_pkg::BYTE_W), .RESET_VAL(sod_pkg::FRAC_RST)) uNumMid (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrNumMid),
      .wrData(regWrData), .value(numMid));

   // Numerator bottom byte.
   sod_cfg_field #(.WIDTH(sod_pkg::BYTE_W), .RESET_VAL(sod_pkg::FRAC_RST)) uNumBot (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrNumBot),
      .wrData(regWrData), .value(numBot));

   // Denominator top six bits, reset zero.
   sod_cfg_field #(.WIDTH(sod_pkg::FRAC_TOP_W), .RESET_VAL(sod_pkg::FRAC_RST)) uDenTop (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrDenTop),
      .wrData(regWrData[sod_pkg::FRAC_TOP_W-1:0]), .value(denTop));

   // Denominator middle byte.
   sod_cfg_field #(.WIDTH(sod_pkg::BYTE_W), .RESET_VAL(sod_pkg::FRAC_RST)) uDenMid (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrDenMid),
      .wrData(regWrData), .value(denMid));

   // Denominator bottom byte.
   sod_cfg_field #(.WIDTH(sod_pkg::BYTE_W), .RESET_VAL(sod_pkg::FRAC_RST)) uDenBot (
      .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrDenBot),
      .wrData(regWrData), .value(denBot));

   // ------------------------------------------------------------------
   // Calibration sequencer.
   // ------------------------------------------------------------------
   sod_pkg::sod_cal_e calState_q;  // Current sequencer state.
   sod_pkg::sod_cal_e calState_d;  // Next sequencer state.
   logic              calStart_q;  // Start pulse register.
   logic              calStart_d;  // Next start pulse.
   logic              calRise;     // Write that takes the trigger from zero to one.

   // A write of one while idle is the zero-to-one edge that starts a run; the
   // bit reads one until the synchronised done flag ends the run. A write of
   // one in the done cycle starts no new run, since the bit was still one.
   always_comb begin
      calRise    = wrCal && regWrData[sod_pkg::CAL_BIT] && (calState_q == sod_pkg::CAL_IDLE);
      calState_d = calState_q;
      calStart_d = 1'b0;
      unique case (calState_q)
         sod_pkg::CAL_IDLE: begin
            if (calRise) begin
               calState_d = sod_pkg::CAL_RUN;
               calStart_d = 1'b1;
            end
         end
         sod_pkg::CAL_RUN: begin
            if (doneSync_q) begin
               calState_d = sod_pkg::CAL_IDLE;
            end
         end
         default: begin
            calState_d = sod_pkg::CAL_IDLE;
         end
      endcase
   end

   // Registers the sequencer.
   always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
         calState_q <= sod_pkg::CAL_IDLE;
         calStart_q <= 1'b0;
      end else begin
         calState_q <= calState_d;
         calStart_q <= calStart_d;
      end
   end

   // ------------------------------------------------------------------
   // Read-back.
   // ------------------------------------------------------------------
   logic [7:0] rdData_q;  // Registered read data.
   logic [7:0] rdData_d;  // Next read data.

   // Selects the addressed register; unmapped addresses and reserved bits read zero, except the output divider upper byte, which reads back all eight stored bits.
   always_comb begin
      rdData_d = rdData_q;
      if (regRdEn) begin
         unique case (regAddr)
            sod_pkg::CAL_CONTROL_ADDR:    rdData_d = {6'h00, calBusyBit(calState_q), 1'b0};
            sod_pkg::TRIM_LOW_ADDR:       rdData_d = {6'h00, trimLow};
            sod_pkg::TRIM_HIGH_ADDR:      rdData_d = trimHigh;
            sod_pkg::DRIVER_CONTROL_ADDR: rdData_d = {drvPd, 5'h00, drvFmt};
            sod_pkg::OUT_DIV_UPPER_ADDR:  rdData_d = outUpper;
            sod_pkg::OUT_DIV_LOWER_ADDR:  rdData_d = outLower;
            sod_pkg::FB_DIV_UPPER_ADDR:   rdData_d = {4'h0, fbUpper};
            sod_pkg::FB_DIV_LOWER_ADDR:   rdData_d = fbLower;
            sod_pkg::NUM_TOP_ADDR:        rdData_d = {2'h0, numTop};
            sod_pkg::NUM_MIDDLE_ADDR:     rdData_d = numMid;
            sod_pkg::NUM_BOTTOM_ADDR:     rdData_d = numBot;
            sod_pkg::DEN_TOP_ADDR:        rdData_d = {2'h0, denTop};
            sod_pkg::DEN_MIDDLE_ADDR:     rdData_d = denMid;
            sod_pkg::DEN_BOTTOM_ADDR:     rdData_d = denBot;
            default:                      rdData_d = sod_pkg::READ_ZERO;
         endcase
      end
   end

   // Registers the read data.
   always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rdData_q <= sod_pkg::READ_ZERO;
      end else begin
         rdData_q <= rdData_d;
      end
   end

   // Calibration bit as seen by software: one while a run is in progress.
   function automatic logic calBusyBit(input sod_pkg::sod_cal_e st);
      calBusyBit = (st == sod_pkg::CAL_RUN);
   endfunction

   // ------------------------------------------------------------------
   // Assembled outputs.
   // ------------------------------------------------------------------
   assign regRdData              = rdData_q;
   assign crystalTrimOffset      = {trimHigh, trimLow};
   assign outputDivider          = {outUpper[sod_pkg::OUT_DIV_HI_BIT], outLower};
   // The divider ratio equals the value; reserved values are flagged, not altered.
   assign outputDividerReserved  = (outputDivider < sod_pkg::OUT_DIV_MIN);
   assign feedbackIntegerDivider = {fbUpper, fbLower};
   assign fractionNumerator      = {numTop, numMid, numBot};
   assign fractionDenominator    = {denTop, denMid, denBot};
   assign calibrationStart       = calStart_q;
   assign calibrationBusy        = (calState_q == sod_pkg::CAL_RUN);
   assign outputBufferPowerdown  = drvPd;
   assign outputFormat           = drvFmt;
   assign formatTristate         = (drvFmt == sod_pkg::FMT_TRISTATE);
   assign formatLvpecl           = (drvFmt == sod_pkg::FMT_LVPECL);
   assign formatLvds             = (drvFmt == sod_pkg::FMT_LVDS);
   assign formatHcsl             = (drvFmt == sod_pkg::FMT_HCSL);

endmodule

// >>> rtl/sod_pkg.sv
// Package with offsets, field layouts, reset values and encodings of the divider register bank.
package sod_pkg;

   // ------------------------------------------------------------------
   // Register byte addresses.
   // ------------------------------------------------------------------
   localparam logic [7:0] CAL_CONTROL_ADDR      = 8'h0A;  // Device control, calibration bit.
   localparam logic [7:0] TRIM_LOW_ADDR         = 8'h10;  // Crystal trim bits 1..0.
   localparam logic [7:0] TRIM_HIGH_ADDR        = 8'h11;  // Crystal trim bits 9..2.
   localparam logic [7:0] DRIVER_CONTROL_ADDR   = 8'h15;  // Output buffer control.
   localparam logic [7:0] OUT_DIV_UPPER_ADDR    = 8'h16;  // Output divider bit 8.
   localparam logic [7:0] OUT_DIV_LOWER_ADDR    = 8'h17;  // Output divider bits 7..0.
   localparam logic [7:0] FB_DIV_UPPER_ADDR     = 8'h19;  // Feedback divider bits 11..8.
   localparam logic [7:0] FB_DIV_LOWER_ADDR     = 8'h1A;  // Feedback divider bits 7..0.
   localparam logic [7:0] NUM_TOP_ADDR          = 8'h1B;  // Numerator bits 21..16.
   localparam logic [7:0] NUM_MIDDLE_ADDR       = 8'h1C;  // Numerator bits 15..8.
   localparam logic [7:0] NUM_BOTTOM_ADDR       = 8'h1D;  // Numerator bits 7..0.
   localparam logic [7:0] DEN_TOP_ADDR          = 8'h1E;  // Denominator bits 21..16.
   localparam logic [7:0] DEN_MIDDLE_ADDR       = 8'h1F;  // Denominator bits 15..8.
   localparam logic [7:0] DEN_BOTTOM_ADDR       = 8'h20;  // Denominator bits 7..0.

   // ------------------------------------------------------------------
   // Stored field widths.
   // ------------------------------------------------------------------
   localparam int BYTE_W       = 8;   // Full register byte.
   localparam int TRIM_LOW_W   = 2;   // Trim bits held in the low register.
   localparam int DRV_FMT_W    = 2;   // Output format field.
   localparam int FB_UPPER_W   = 4;   // Feedback divider upper nibble.
   localparam int FRAC_TOP_W   = 6;   // Top part of numerator and denominator.
   localparam int OUT_DIV_W    = 9;   // Output divider width.
   localparam int FB_DIV_W     = 12;  // Feedback divider width.
   localparam int FRAC_W       = 22;  // Fraction numerator and denominator width.
   localparam int TRIM_W       = 10;  // Crystal trim offset width.

   // ------------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------------
   localparam int DRV_PD_BIT     = 7;  // Output buffer power-down bit.
   localparam int CAL_BIT        = 1;  // Calibration trigger bit.
   localparam int OUT_DIV_HI_BIT = 0;  // Output divider bit 8 in the upper register.

   // ------------------------------------------------------------------
   // Reset values.
   // ------------------------------------------------------------------
   localparam logic [7:0] TRIM_LOW_RST    = 8'h00;
   localparam logic [7:0] TRIM_HIGH_RST   = 8'h80;
   localparam logic [7:0] OUT_UPPER_RST   = 8'h00;
   localparam logic [7:0] OUT_LOWER_RST   = 8'h20;
   localparam logic [7:0] FB_UPPER_RST    = 8'h00;
   localparam logic [7:0] FB_LOWER_RST    = 8'h32;
   localparam logic [7:0] FRAC_RST        = 8'h00;
   localparam logic [7:0] READ_ZERO       = 8'h00;
   localparam logic       PD_RST          = 1'b0;

   // Smallest output divider value that is not reserved.
   localparam logic [8:0] OUT_DIV_MIN     = 9'h005;

   // Output driver format encodings.
   typedef enum logic [1:0] {
      FMT_TRISTATE = 2'h0,
      FMT_LVPECL   = 2'h1,
      FMT_LVDS     = 2'h2,
      FMT_HCSL     = 2'h3
   } sod_fmt_e;

   // Calibration sequencer states, one-hot.
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b01,
      CAL_RUN  = 2'b10
   } sod_cal_e;

endpackage

// >>> test/sod_divider_regs_monitor.sv
// Port assertions for the divider register bank.
`timescale 1ns/10ps
module sod_divider_regs_monitor (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [7:0]  regAddr,
   input wire logic [7:0]  regWrData,
   input wire logic        regWrEn,
   input wire logic [9:0]  crystalTrimOffset,
   input wire logic [8:0]  outputDivider,
   input wire logic        outputDividerReserved,
   input wire logic [21:0] fractionNumerator,
   input wire logic        calibrationStart,
   input wire logic        calibrationBusy,
   input wire logic        outputBufferPowerdown,
   input wire logic [1:0]  outputFormat,
   input wire logic        formatTristate,
   input wire logic        formatLvpecl,
   input wire logic        formatLvds,
   input wire logic        formatHcsl
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_trHi; regWrEn && regAddr == 8'h11 |=> crystalTrimOffset[9:2] == $past(regWrData); endproperty
   a_trHi: assert property (p_trHi) else $error("trim high byte");
   property p_trLo; regWrEn && regAddr == 8'h10 |=> crystalTrimOffset[1:0] == $past(regWrData[1:0]); endproperty
   a_trLo: assert property (p_trLo) else $error("trim low bits");
   property p_pd; regWrEn && regAddr == 8'h15 |=> outputBufferPowerdown == $past(regWrData[7]); endproperty
   a_pd: assert property (p_pd) else $error("power-down bit");
   property p_fmt; {formatHcsl, formatLvds, formatLvpecl, formatTristate} == 4'h1 << outputFormat; endproperty
   a_fmt: assert property (p_fmt) else $error("format decode");
   property p_rsv; outputDividerReserved == (outputDivider < 9'h005); endproperty
   a_rsv: assert property (p_rsv) else $error("reserved divider flag");
   property p_odHi; regWrEn && regAddr == 8'h16 |=> outputDivider[8] == $past(regWrData[0]); endproperty
   a_odHi: assert property (p_odHi) else $error("divider bit 8");
   property p_num; regWrEn && regAddr == 8'h1B |=> fractionNumerator[21:16] == $past(regWrData[5:0]); endproperty
   a_num: assert property (p_num) else $error("numerator top");
   property p_cal; regWrEn && regAddr == 8'h0A && regWrData[1] && !calibrationBusy
      |=> calibrationStart && calibrationBusy ##1 !calibrationStart; endproperty
   a_cal: assert property (p_cal) else $error("calibration start");
endmodule
bind sod_divider_regs sod_divider_regs_monitor u_mon (.clock, .rst_n, .regAddr, .regWrData,
   .regWrEn, .crystalTrimOffset, .outputDivider, .outputDividerReserved, .fractionNumerator,
   .calibrationStart, .calibrationBusy, .outputBufferPowerdown, .outputFormat,
   .formatTristate, .formatLvpecl, .formatLvds, .formatHcsl);

// >>> test/sod_host_model.sv
// Host model issuing single-cycle register writes and reads.
`timescale 1ns/10ps
module sod_host_model (
   input  wire logic       clock,
   output logic      [7:0] regAddr,
   output logic      [7:0] regWrData,
   output logic            regWrEn,
   output logic            regRdEn,
   input  wire logic [7:0] regRdData
);
   initial {regAddr, regWrData, regWrEn, regRdEn} = '0;
   // Released lines are inverted so stale values never look valid.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock) {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
      @(negedge clock) {regAddr, regWrData, regWrEn} = {~a, ~d, 1'b0};
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock) {regAddr, regRdEn} = {a, 1'b1};
      @(negedge clock) {regAddr, regRdEn} = {~a, 1'b0};
      d = regRdData;
   endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench comparing the register bank with a byte model.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin numErrors++; \
   $display("unexpected %0t %0h %0h", $time, g, e); end end
module tb_top;
   logic        clock = 1'b0, rst_n = 1'b0, calibrationDone = 1'b0;
   logic [7:0]  regAddr, regWrData, regRdData, rdv;
   logic        regWrEn, regRdEn, outputDividerReserved, calibrationStart, calibrationBusy;
   logic        outputBufferPowerdown, formatTristate, formatLvpecl, formatLvds, formatHcsl;
   logic [9:0]  crystalTrimOffset;
   logic [8:0]  outputDivider;
   logic [11:0] feedbackIntegerDivider;
   logic [21:0] fractionNumerator, fractionDenominator;
   logic [1:0]  outputFormat;
   int          numErrors = 0, compares = 0, r[256], msk[256], n;
   int          tbl[$] = '{8'h10, 8'h03, 0, 8'h11, 8'hFF, 8'h80, 8'h15, 8'h83, 1, 8'h16, 8'hFF, 0,
      8'h17, 8'hFF, 8'h20, 8'h19, 8'h0F, 0, 8'h1A, 8'hFF, 8'h32, 8'h1B, 8'h3F, 0, 8'h1C, 8'hFF, 0,
      8'h1D, 8'hFF, 0, 8'h1E, 8'h3F, 0, 8'h1F, 8'hFF, 0, 8'h20, 8'hFF, 0, 8'h30, 0, 0};
   int          fix[$] = '{8'h16, 0, 8'h17, 4, 8'h17, 5, 8'h16, 8'hFF, 8'h17, 8'hFF,
      8'h15, 0, 8'h15, 8'h41, 8'h15, 8'h82, 8'h15, 8'hC3};
   initial forever #10 clock = ~clock;
   sod_host_model u_host (.clock, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData);
   sod_divider_regs u_dut (.clock, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
      .crystalTrimOffset, .outputDivider, .outputDividerReserved, .feedbackIntegerDivider,
      .fractionNumerator, .fractionDenominator, .calibrationStart, .calibrationBusy,
      .calibrationDone, .outputBufferPowerdown, .outputFormat, .formatTristate, .formatLvpecl,
      .formatLvds, .formatHcsl);
   // Writes update the model only where the byte is mapped, through its writable mask.
   task automatic wr(input int a, input int d);
      u_host.wr(8'(a), 8'(d));
      r[a] = d & msk[a];
   endtask
   task automatic rdAll;
      for (int i = 0; i < tbl.size(); i += 3) begin
         u_host.rd(8'(tbl[i]), rdv);
         `CHK(rdv, 8'(r[tbl[i]]))
      end
   endtask
   task automatic chk;
      `CHK(crystalTrimOffset, 10'({r[8'h11], r[8'h10][1:0]}))
      `CHK(outputDivider, 9'({r[8'h16][0], r[8'h17][7:0]}))
      `CHK(outputDividerReserved, 1'({r[8'h16][0], r[8'h17][7:0]} < 9'h005))
      `CHK(feedbackIntegerDivider, 12'({r[8'h19][3:0], r[8'h1A][7:0]}))
      `CHK(fractionNumerator, 22'({r[8'h1B][5:0], r[8'h1C][7:0], r[8'h1D][7:0]}))
      `CHK(fractionDenominator, 22'({r[8'h1E][5:0], r[8'h1F][7:0], r[8'h20][7:0]}))
      `CHK(outputBufferPowerdown, 1'(r[8'h15][7]))
      `CHK({formatHcsl, formatLvds, formatLvpecl, formatTristate}, 4'h1 << r[8'h15][1:0])
      `CHK(outputFormat, 2'(r[8'h15][1:0]))
   endtask
   task completeRun;
      if (numErrors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h8919));
      for (int i = 0; i < tbl.size(); i += 3) {msk[tbl[i]], r[tbl[i]]} = {tbl[i+1], tbl[i+2]};
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      chk();
      rdAll();
      for (int i = 0; i < fix.size(); i += 2) begin
         wr(fix[i], fix[i+1]);
         chk();
      end
      repeat (60) begin
         n = $urandom_range(13);
         wr(tbl[3*n], $urandom_range(255));
         chk();
      end
      rdAll();
      wr(8'h0A, 8'h02);
      `CHK({calibrationStart, calibrationBusy}, 2'b11)
      u_host.rd(8'h0A, rdv);
      `CHK(rdv, 8'h02)
      wr(8'h0A, 8'h02);
      `CHK(calibrationStart, 1'b0)
      @(negedge clock) calibrationDone = 1'b1;
      for (n = 0; n < 20 && calibrationBusy !== 1'b0; n++) @(negedge clock);
      if (n == 20) begin
         numErrors++;
         completeRun();
      end
      `CHK(n, 3)
      calibrationDone = 1'b0;
      wr(8'h0A, 8'h02);
      `CHK({calibrationStart, calibrationBusy}, 2'b11)
      completeRun();
   end
endmodule
